// ---- logic/fc_login_regs.svh ----
// Summary of operation
// - Initiator sets continuously increasing offset flag.
// - Offset flag clear: reject, reason 03h/0Fh.
// - Relative offset present only when F_CTL bit3 set.
// - Accept returns offset and alternate credit flags one.
// - Accept clears remaining common feature flags.
// - Resolution flag: one means 1 ns, zero 1 ms.
// - Payload flag: one 256 bytes, zero 116.
// - N/F flag: one fabric port, zero node.
// - Data field size 256..2112, multiple of four.
// - Zero concurrent sequences rejected 03h/09h; accept FFh.
// - Offset-by-category accept value 0002h.
// - Timeout value unchecked, returned as zero.
// - Only class 3 parameters are checked.
// - Class 3 validity clear: reject 03h/01h.
// - Class 3 options byte accept default 80h.
// - Intermix, transparent, lock, sequential returned zero.
// - Buffer credit field returned zero.
`ifndef FC_LOGIN_REGS_SVH
`define FC_LOGIN_REGS_SVH
// Common feature bit positions in word 2 upper half
`define CF_CIO_BIT      15
`define CF_RRO_BIT      14
`define CF_VV_BIT       13
`define CF_NF_BIT       12
`define CF_ABCM_BIT     11
`define CF_EDRES_BIT    10
`define CF_DS_BIT       6
`define CF_DHD_BIT      2
`define CF_SEQCNT_BIT   1
`define CF_PL_BIT       0
`define FCTL_RO_BIT     3
// Reject codes
`define RJT_REASON      8'h03
`define RJT_EXP_COMMON  8'h0F
`define RJT_EXP_CONCUR  8'h09
`define RJT_EXP_OPTIONS 8'h01
`define RJT_EXP_RXSIZE  8'h07
// Limits and accept values
`define RXSIZE_MIN      12'h100
`define RXSIZE_MAX      12'h840
`define ACC_FEATURES    16'h8800
`define ACC_CONCUR      16'h00FF
`define ACC_ROCAT       16'h0002
`define ACC_EDTOV       32'h00000000
`define ACC_BBCREDIT    16'h0000
`define ACC_OPTIONS     8'h80
`define OPT_CV_BIT      7
`define CHECK_CYCLES    2'h2
`define CTRL_RESET      1'b1
// Software register offsets
`define REG_STATUS      4'h0
`define REG_IRQ_CLEAR   4'h1
`define REG_IRQ_ENABLE  4'h2
`define REG_RESULT      4'h3
`define REG_CTRL        4'h4
`endif

// ---- logic/fc_login_pkg.sv ----
`default_nettype none
package fc_login_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_REPLY = 2'b10
  } dev_state_t;
  // Login request fields
  typedef struct packed
  {
    logic [15:0] features;
    logic [15:0] bbCredit;
    logic [11:0] rxSize;
    logic [15:0] concurSeq;
    logic [15:0] roCategory;
    logic [31:0] edTov;
    logic [7:0]  class3Options;
    logic [7:0]  fCtl;
  } login_param_t;
endpackage
`default_nettype wire

// ---- logic/fc_login_if.sv ----
`default_nettype none
interface fc_login_if;
  logic                        reqValid;
  fc_login_pkg::login_param_t  reqParam;
  logic                        rspValid;
  logic                        rspAccept;
  logic [7:0]                  rspReason;
  logic [7:0]                  rspExplain;
  fc_login_pkg::login_param_t  rspParam;
  logic                        roPresent;
  modport device
  (
    input  reqValid,
    input  reqParam,
    output rspValid,
    output rspAccept,
    output rspReason,
    output rspExplain,
    output rspParam,
    output roPresent
  );
  modport initiator
  (
    output reqValid,
    output reqParam,
    input  rspValid,
    input  rspAccept,
    input  rspReason,
    input  rspExplain,
    input  rspParam,
    input  roPresent
  );
endinterface
`default_nettype wire

// ---- logic/fc_login_device.sv ----
// The implementer's own choices: the address map and the address-and-strobe port.
`include "fc_login_regs.svh"
`default_nettype none
module fc_login_device
(
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  // Link side
  fc_login_if.device         link,
  // Software port
  input  wire logic [3:0]    regAddr,
  input  wire logic [31:0]   regWrData,
  input  wire logic          regWrite,
  input  wire logic          regRead,
  output logic [31:0]        regRdData,
  output logic               irq
);
  // ****************************************
  // State
  // ****************************************
  // One record holds all state so reset and update stay in step
  typedef struct packed
  {
    fc_login_pkg::dev_state_t    state;
    logic [1:0]                  count;
    fc_login_pkg::login_param_t  req;
    logic                        rspValid;
    logic                        rspAccept;
    logic [7:0]                  rspReason;
    logic [7:0]                  rspExplain;
    fc_login_pkg::login_param_t  rspParam;
    logic                        roPresent;
    logic [2:0]                  status;
    logic [2:0]                  enable;
    logic                        checkRxSize;
    logic [31:0]                 rdData;
    logic                        irq;
  } dev_t;

  dev_t cur_reg;
  dev_t cur_next;

  // ****************************************
  // Checks
  // ****************************************
  // Size window and word alignment of the receive data field
  function automatic logic sizeBad
  (
    input logic [11:0] size
  );
    sizeBad = (size < `RXSIZE_MIN) || (size > `RXSIZE_MAX)
              || (size[1:0] != 2'b00);
  endfunction

  // Reject explanation, or zero when every check passes
  // Priority matters: a request with several faults reports only the first
  // A bad size reuses 0Fh, one code for every common field fault
  function automatic logic [7:0] rejectExplain
  (
    input fc_login_pkg::login_param_t req,
    input logic                       sizeOn
  );
    // Timeout value and the other classes are never inspected
    if (!req.features[`CF_CIO_BIT])
      rejectExplain = `RJT_EXP_COMMON;
    else if (sizeOn && sizeBad(req.rxSize))
      rejectExplain = `RJT_EXP_COMMON;
    else if (req.concurSeq == 16'h0000)
      rejectExplain = `RJT_EXP_CONCUR;
    else if (!req.class3Options[`OPT_CV_BIT])
      rejectExplain = `RJT_EXP_OPTIONS;
    else
      rejectExplain = 8'h00;
  endfunction

  // Fixed accept payload; of the request only the size is echoed
  // Fields not named here go out as zero
  function automatic fc_login_pkg::login_param_t acceptPayload
  (
    input logic [11:0] size
  );
    acceptPayload = '0;
    acceptPayload.features = `ACC_FEATURES;
    acceptPayload.bbCredit = `ACC_BBCREDIT;
    acceptPayload.rxSize = size;
    acceptPayload.concurSeq = `ACC_CONCUR;
    acceptPayload.roCategory = `ACC_ROCAT;
    acceptPayload.edTov = `ACC_EDTOV;
    acceptPayload.class3Options = `ACC_OPTIONS;
  endfunction

  // Read decode; unmapped and write-only words read as zero
  function automatic logic [31:0] readWord
  (
    input logic [3:0] addr,
    input dev_t       cur
  );
    unique case (addr)
      `REG_STATUS:     readWord = {29'h0, cur.status};
      `REG_IRQ_ENABLE: readWord = {29'h0, cur.enable};
      `REG_RESULT:     readWord = {15'h0, cur.rspAccept, cur.rspReason,
                                   cur.rspExplain};
      `REG_CTRL:       readWord = {31'h0, cur.checkRxSize};
      default:         readWord = 32'h00000000;
    endcase
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  // Register map, by word index:
  //   0 status, read only: bit 2 reply, bit 1 reject, bit 0 accept
  //   1 clear, write ones to drop status bits
  //   2 interrupt enable, same layout as status
  //   3 last result: accept bit 16, reason 15:8, explanation 7:0
  //   4 control: bit 0 turns the size check on, set by reset
  // One request at a time; the answer always takes the same cycle count
  always_comb
  begin
    logic [2:0] evt;
    logic [2:0] clr;
    evt = 3'h0;
    clr = 3'h0;
    cur_next = cur_reg;
    cur_next.rspValid = 1'b0;
    unique case (cur_reg.state)
      fc_login_pkg::ST_IDLE:
      begin
        // A request while busy is dropped; the initiator keeps one open
        if (link.reqValid)
        begin
          cur_next.req = link.reqParam;
          cur_next.count = `CHECK_CYCLES;
          cur_next.state = fc_login_pkg::ST_CHECK;
        end
      end
      fc_login_pkg::ST_CHECK:
      begin
        // Fixed wait hides which check failed from the answer time
        cur_next.count = cur_reg.count - 2'h1;
        if (cur_reg.count == 2'h1)
          cur_next.state = fc_login_pkg::ST_REPLY;
      end
      fc_login_pkg::ST_REPLY:
      begin
        cur_next.rspValid = 1'b1;
        cur_next.roPresent = cur_reg.req.fCtl[`FCTL_RO_BIT];
        cur_next.rspExplain = rejectExplain(cur_reg.req, cur_reg.checkRxSize);
        // Accept only when no check found a fault
        cur_next.rspAccept = (cur_next.rspExplain == 8'h00);
        if (cur_next.rspAccept)
          cur_next.rspReason = 8'h00;
        else
          cur_next.rspReason = `RJT_REASON;
        // Payload is sent on both answers; it only counts with an accept
        cur_next.rspParam = acceptPayload(cur_reg.req.rxSize);
        // Event bits: 0 accept, 1 reject, 2 any reply
        evt = {1'b1, ~cur_next.rspAccept, cur_next.rspAccept};
        cur_next.state = fc_login_pkg::ST_IDLE;
      end
      default:
        cur_next.state = fc_login_pkg::ST_IDLE;
    endcase
    // Software port; an event in this cycle wins over its clear
    cur_next.rdData = 32'h00000000;
    if (regWrite && regAddr == `REG_IRQ_CLEAR)
      clr = regWrData[2:0];
    cur_next.status = (cur_reg.status & ~clr) | evt;
    if (regWrite && regAddr == `REG_IRQ_ENABLE)
      cur_next.enable = regWrData[2:0];
    if (regWrite && regAddr == `REG_CTRL)
      cur_next.checkRxSize = regWrData[0];
    if (regRead)
      cur_next.rdData = readWord(regAddr, cur_reg);
    cur_next.irq = |(cur_next.status & cur_next.enable);
  end

  // ****************************************
  // Registers
  // ****************************************
  // Synchronous reset; the size check comes up enabled
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cur_reg <= '0;
      cur_reg.state <= fc_login_pkg::ST_IDLE;
      cur_reg.checkRxSize <= `CTRL_RESET;
    end
    else
      cur_reg <= cur_next;
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a register bit; nothing combinational leaves
  // Reply fields hold until the next reply overwrites them, except rspValid, which is high for one cycle only
  assign link.rspValid = cur_reg.rspValid;
  assign link.rspAccept = cur_reg.rspAccept;
  assign link.rspReason = cur_reg.rspReason;
  assign link.rspExplain = cur_reg.rspExplain;
  assign link.rspParam = cur_reg.rspParam;
  assign link.roPresent = cur_reg.roPresent;
  assign regRdData = cur_reg.rdData;
  assign irq = cur_reg.irq;
endmodule
`default_nettype wire

// ---- logic/fc_login_initiator.sv ----
`include "fc_login_regs.svh"
`default_nettype none
module fc_login_initiator
(
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // Link side
  fc_login_if.initiator                    link,
  // User side
  input  wire logic                        loginStart,
  input  wire fc_login_pkg::login_param_t  loginParam,
  output logic                             loginDone,
  output logic                             loginAccepted,
  output logic [7:0]                       loginExplain,
  output logic                             peerIsFabric,
  output logic                             edTovNs,
  output logic                             longPayload
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed
  {
    logic                        busy;
    logic                        reqValid;
    fc_login_pkg::login_param_t  reqParam;
    logic                        done;
    logic                        accepted;
    logic [7:0]                  explain;
    logic                        fabric;
    logic                        edNs;
    logic                        longPl;
  } ini_t;

  ini_t cur_reg;
  ini_t cur_next;

  // Send one request, wait for the single reply
  always_comb
  begin
    cur_next = cur_reg;
    cur_next.reqValid = 1'b0;
    cur_next.done = 1'b0;
    if (!cur_reg.busy && loginStart)
    begin
      cur_next.reqParam = loginParam;
      cur_next.reqParam.features[`CF_CIO_BIT] = 1'b1;
      cur_next.reqValid = 1'b1;
      cur_next.busy = 1'b1;
    end
    if (cur_reg.busy && link.rspValid)
    begin
      cur_next.busy = 1'b0;
      cur_next.done = 1'b1;
      cur_next.accepted = link.rspAccept;
      cur_next.explain = link.rspExplain;
      cur_next.fabric = link.rspParam.features[`CF_NF_BIT];
      cur_next.edNs = link.rspParam.features[`CF_EDRES_BIT];
      cur_next.longPl = link.rspParam.features[`CF_PL_BIT];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cur_reg <= '0;
    else
      cur_reg <= cur_next;
  end

  assign link.reqValid = cur_reg.reqValid;
  assign link.reqParam = cur_reg.reqParam;
  assign loginDone = cur_reg.done;
  assign loginAccepted = cur_reg.accepted;
  assign loginExplain = cur_reg.explain;
  assign peerIsFabric = cur_reg.fabric;
  assign edTovNs = cur_reg.edNs;
  assign longPayload = cur_reg.longPl;
endmodule
`default_nettype wire

// ---- testbench/fc_login_chk.sv ----
`default_nettype none
// ********************
// Login reply checker
// ********************
module fc_login_chk
(
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       sys_rst,
  // Link signals
  input wire logic                       reqValid,
  input wire fc_login_pkg::login_param_t reqParam,
  input wire logic                       rspValid,
  input wire logic                       rspAccept,
  input wire logic [7:0]                 rspReason,
  input wire logic [7:0]                 rspExplain,
  input wire fc_login_pkg::login_param_t rspParam,
  input wire logic                       roPresent
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic cio;
  wire logic rxOk;
  // Request qualifiers; size check assumed enabled on this link
  assign cio  = reqParam.features[15];
  assign rxOk = reqParam.rxSize >= 12'h100 && reqParam.rxSize <= 12'h840
                && reqParam.rxSize[1:0] == 2'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Reply codes follow check priority four edges on
  a_cio_reject: assert property (reqValid && !cio |-> ##4 rspValid && !rspAccept
    && rspReason == 8'h03 && rspExplain == 8'h0F) else $error("offset flag reject");
  a_concur_reject: assert property (reqValid && cio && rxOk && reqParam.concurSeq == 16'h0
    |-> ##4 rspValid && !rspAccept && rspExplain == 8'h09) else $error("concur reject");
  a_class_reject: assert property (reqValid && cio && rxOk && reqParam.concurSeq != 16'h0
    && !reqParam.class3Options[7] |-> ##4 rspValid && !rspAccept && rspReason == 8'h03
    && rspExplain == 8'h01) else $error("class validity reject");
  a_accept_all: assert property (reqValid && cio && rxOk && reqParam.concurSeq != 16'h0
    && reqParam.class3Options[7] |-> ##4 rspValid && rspAccept) else $error("no accept");
  // Fixed accept fields regardless of what was asked; the echoed size is not checked
  a_acc_features: assert property (rspValid && rspAccept |->
    rspParam.features == 16'h8800) else $error("accept features");
  a_acc_fields: assert property (rspValid && rspAccept |-> rspParam.concurSeq == 16'h00FF
    && rspParam.roCategory == 16'h0002 && rspParam.edTov == 32'h0
    && rspParam.bbCredit == 16'h0) else $error("accept fields");
  a_acc_options: assert property (rspValid && rspAccept |->
    rspParam.class3Options == 8'h80) else $error("accept options");
  a_ro_flag: assert property (rspValid |-> roPresent == $past(reqParam.fCtl[3], 4))
    else $error("offset present flag");
endmodule
`default_nettype wire

// ---- testbench/tb_fc_login_service_param_checker.sv ----
`default_nettype none
// ********************
// Login bench
// ********************
module tb_fc_login_service_param_checker;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed
  {
    logic [11:0] sz;
    logic [15:0] cs;
    logic [7:0]  op;
    logic        ac;
    logic [7:0]  ex;
  } row_t;
  localparam row_t ROWS [8] = '{
    '{12'h800, 16'h0001, 8'hFF, 1'b1, 8'h00}, '{12'h100, 16'h0001, 8'h80, 1'b1, 8'h00},
    '{12'h840, 16'hFFFF, 8'h80, 1'b1, 8'h00}, '{12'h0FC, 16'h0001, 8'h80, 1'b0, 8'h0F},
    '{12'h844, 16'h0001, 8'h80, 1'b0, 8'h0F}, '{12'h102, 16'h0001, 8'h80, 1'b0, 8'h0F},
    '{12'h800, 16'h0000, 8'h80, 1'b0, 8'h09}, '{12'h800, 16'h0001, 8'h7F, 1'b0, 8'h01}};
  logic                       clk_sys = 1'b0;
  logic                       sys_rst = 1'b1;
  logic                       loginStart = 1'b0;
  fc_login_pkg::login_param_t loginParam = '0;
  logic                       loginDone, loginAccepted, peerIsFabric, edTovNs, longPayload, irq;
  logic [7:0]                 loginExplain;
  logic [3:0]                 regAddr = 4'h0;
  logic [31:0]                regWrData = 32'h0, regRdData, rdVal;
  logic                       regWrite = 1'b0, regRead = 1'b0;
  int                         miscompares = 0, checked = 0;
  fc_login_if link ();
  fc_login_if linkB ();
  fc_login_device fc_login_device_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .irq(irq));
  // Second device faces the bench, which breaks the offset flag rule on purpose
  fc_login_device fc_login_device_inst2 (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(linkB),
    .regAddr(4'h0), .regWrData(32'h0), .regWrite(1'b0), .regRead(1'b0), .regRdData(), .irq());
  fc_login_initiator fc_login_initiator_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
    .loginStart(loginStart), .loginParam(loginParam), .loginDone(loginDone),
    .loginAccepted(loginAccepted), .loginExplain(loginExplain), .peerIsFabric(peerIsFabric),
    .edTovNs(edTovNs), .longPayload(longPayload));
  fc_login_chk fc_login_chk_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reqValid(link.reqValid), .reqParam(link.reqParam), .rspValid(link.rspValid),
    .rspAccept(link.rspAccept), .rspReason(link.rspReason), .rspExplain(link.rspExplain),
    .rspParam(link.rspParam), .roPresent(link.roPresent));
  // Clock
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 rdVal = regRdData;
  endtask
  // Offset flag sent clear: the initiator must set it itself
  task automatic login(input row_t r);
    @(posedge clk_sys);
    loginParam <= '{16'h7FFF, 16'h0005, r.sz, r.cs, 16'h00FF, 32'h1234, r.op, 8'h08};
    loginStart <= 1'b1;
    @(posedge clk_sys);
    loginStart <= 1'b0;
    repeat (12) if (loginDone !== 1'b1) @(posedge clk_sys) #1;
    chk(32'(loginDone), 32'h1);
  endtask
  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog, far beyond the hundred or so cycles expected
  initial
  begin
    #20000;
    miscompares++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    linkB.reqValid = 1'b0;
    linkB.reqParam = '0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (ROWS[i])
    begin
      login(ROWS[i]);
      chk(32'(loginAccepted), 32'(ROWS[i].ac));
      if (!ROWS[i].ac) chk(32'(loginExplain), 32'(ROWS[i].ex));
      else chk(32'({peerIsFabric, edTovNs, longPayload}), 32'h0);
      $display("row %0d done", i);
    end
    rd(4'h0);
    chk(rdVal, 32'h7);
    rd(4'h3);
    chk(rdVal, 32'h0000_0301);
    chk(32'(irq), 32'h0);
    wr(4'h2, 32'h2);
    rd(4'h2);
    chk(rdVal, 32'h2);
    chk(32'(irq), 32'h1);
    wr(4'h1, 32'h7);
    rd(4'h0);
    chk(rdVal, 32'h0);
    rd(4'hF);
    chk(rdVal, 32'h0);
    chk(32'(irq), 32'h0);
    $display("register test done");
    // Reply event and clear land on one edge: the event must survive
    fork
      login(ROWS[0]);
      begin
        repeat (4) @(posedge clk_sys);
        wr(4'h1, 32'h7);
      end
    join
    rd(4'h0);
    chk(rdVal, 32'h5);
    $display("set over clear done");
    wr(4'h4, 32'h0);
    login('{12'h0FC, 16'h0001, 8'h80, 1'b1, 8'h00});
    chk(32'(loginAccepted), 32'h1);
    $display("size check off done");
    @(posedge clk_sys);
    linkB.reqParam <= '{16'h0800, 16'h0, 12'h800, 16'h1, 16'h0, 32'h0, 8'h80, 8'h00};
    linkB.reqValid <= 1'b1;
    @(posedge clk_sys);
    linkB.reqValid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk(32'({linkB.rspValid, linkB.rspAccept, linkB.roPresent, linkB.rspReason,
      linkB.rspExplain}), 32'h0004_030F);
    $display("offset flag test done");
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(4'h4);
    chk(rdVal, 32'h1);
    chk(32'({irq, loginDone, loginAccepted, link.rspAccept, link.rspValid}), 32'h0);
    $display("reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
